// ### logic/udma_burst_host.sv
// Host end of Ultra DMA data-out bursts with burst checksum and bus port.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps

module udma_burst_host (
   input wire logic clock,
   input wire logic srst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic dmarq,
   input wire logic ddmardy_n,
   input wire logic [15:0] d_in,
   output logic [15:0] d_out,
   output logic d_oe,
   output logic hstrobe,
   output logic stop,
   output logic dmack_n
);
   import udma_host_pkg::*;

   typedef struct packed {
      udma_host_pkg::state_t state;
      logic [7:0] timer;
      logic [15:0] remain;
      logic [15:0] word;
      logic pending;
      logic ultra;
      logic busy;
      logic done;
      logic stop_req;
      logic [7:0] bursts;
      logic [15:0] sent_crc;
      logic rq_meta;
      logic rq_sync;
      logic rdy_meta;
      logic rdy_sync;
      logic hstrobe;
      logic stop;
      logic dmack_n;
      logic [15:0] d_out;
      logic d_oe;
      logic ack;
      logic [31:0] rdat;
   } host_t;

   host_t r;
   host_t next_r;
   logic crc_load;
   logic crc_update;
   logic [15:0] crc_value;
   logic bus_req;
   logic word_ready;

   ////////////////////////////////////////////////////////////////////////
   // Checksum register, stepped only on strobe toggles of the burst.
   udma_crc16 crc (
      .clock(clock),
      .srst(srst),
      .load(crc_load),
      .update(crc_update),
      .word(r.word),
      .value(crc_value)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus slave, pin synchronisers and burst sequencer.
   always_comb begin
      next_r = r;
      crc_load = 1'b0;
      crc_update = 1'b0;
      // Two-stage synchronisers for the device's pins.
      next_r.rq_meta = dmarq;
      next_r.rq_sync = r.rq_meta;
      next_r.rdy_meta = ddmardy_n;
      next_r.rdy_sync = r.rdy_meta;
      next_r.ack = 1'b0;
      // One shared down-counter times strobe spacing and the end phases.
      if (r.timer != TIMER_RESET) begin
         next_r.timer = r.timer - 8'h01;
      end
      // Taking a request only while ack is low gives one ack per request.
      bus_req = cyc_i && stb_i && !r.ack;
      // The word on the pins must have stood one cycle before a toggle.
      word_ready = r.pending && (r.d_out == r.word);

      // Bus slave; a word write waits while the previous word is unsent.
      if (bus_req) begin
         if (we_i && adr_i == REG_WORD) begin
            if (!r.pending) begin
               next_r.word = lane_merge(r.word, dat_i, sel_i);
               next_r.pending = 1'b1;
               next_r.ack = 1'b1;
            end
         end else begin
            next_r.ack = 1'b1;
            next_r.rdat = 32'h0000_0000;
            if (we_i) begin
               if (adr_i == REG_CTRL) begin
                  if (sel_i[0]) begin
                     next_r.ultra = dat_i[CTRL_ULTRA];
                     if (dat_i[CTRL_STOP] && r.busy) begin
                        next_r.stop_req = 1'b1;
                     end
                     // Starting needs an Ultra mode and a nonzero count.
                     if (dat_i[CTRL_START] && dat_i[CTRL_ULTRA]
                         && r.state == ST_IDLE
                         && r.remain != WORD_RESET) begin
                        next_r.busy = 1'b1;
                        next_r.done = 1'b0;
                        next_r.bursts = 8'h00;
                        next_r.state = ST_WAIT_RQ;
                     end
                  end
               end else if (adr_i == REG_COUNT) begin
                  if (!r.busy) begin
                     next_r.remain = lane_merge(r.remain, dat_i, sel_i);
                  end
               end
            end else begin
               if (adr_i == REG_CTRL) begin
                  next_r.rdat[CTRL_ULTRA] = r.ultra;
               end else if (adr_i == REG_COUNT) begin
                  next_r.rdat[15:0] = r.remain;
               end else if (adr_i == REG_WORD) begin
                  next_r.rdat[15:0] = r.word;
               end else if (adr_i == REG_STATUS) begin
                  next_r.rdat[STAT_BUSY] = r.busy;
                  next_r.rdat[STAT_PENDING] = r.pending;
                  next_r.rdat[STAT_DONE] = r.done;
                  next_r.rdat[STAT_ULTRA] = r.ultra;
                  next_r.rdat[STAT_STOP] = r.stop_req;
                  next_r.rdat[STAT_BURSTS +: 8] = r.bursts;
               end else if (adr_i == REG_CRC) begin
                  next_r.rdat[15:0] = r.sent_crc;
               end
            end
         end
      end

      // Burst sequencer.
      case (r.state)
         ST_IDLE: begin
            next_r.stop = 1'b0;
         end
         // Acknowledge the device's request and seed the checksum.
         ST_WAIT_RQ: begin
            if (r.rq_sync) begin
               next_r.dmack_n = 1'b0;
               next_r.stop = 1'b0;
               next_r.hstrobe = 1'b1;
               next_r.d_oe = 1'b1;
               next_r.d_out = r.word;
               crc_load = 1'b1;
               next_r.bursts = r.bursts + 8'h01;
               next_r.timer = STROBE_CYC;
               next_r.state = ST_SEND;
            end
         end
         // Each toggle carries one word; a high ready pin pauses us.
         ST_SEND: begin
            next_r.d_out = r.word;
            if (!r.rq_sync || r.stop_req || r.remain == WORD_RESET) begin
               next_r.stop = 1'b1;
               next_r.timer = TSS_CYC;
               next_r.state = ST_STOP;
            end else if (r.timer == TIMER_RESET && !r.rdy_sync
                         && word_ready) begin
               next_r.hstrobe = !r.hstrobe;
               crc_update = 1'b1;
               next_r.pending = 1'b0;
               next_r.remain = r.remain - 16'h0001;
               next_r.timer = STROBE_CYC;
            end
         end
         // Hold stop until the device drops its request.
         ST_STOP: begin
            // Waiting for the request to drop keeps the strobe steady.
            if (!r.rq_sync && r.timer == TIMER_RESET) begin
               // Returning the strobe high carries no word.
               next_r.hstrobe = 1'b1;
               next_r.d_out = crc_value;
               next_r.timer = TDVS_CYC;
               next_r.state = ST_CRC;
            end
         end
         // Checksum on the lines, then release acknowledge with it.
         ST_CRC: begin
            if (r.timer == TIMER_RESET) begin
               next_r.dmack_n = 1'b1;
               next_r.sent_crc = r.d_out;
               next_r.timer = TACK_CYC;
               next_r.state = ST_RELEASE;
            end
         end
         // Command ends when the count is spent or software stopped it.
         ST_RELEASE: begin
            if (r.timer == TIMER_RESET) begin
               next_r.stop = 1'b0;
               next_r.d_oe = 1'b0;
               if (r.remain == WORD_RESET || r.stop_req) begin
                  next_r.busy = 1'b0;
                  next_r.done = 1'b1;
                  next_r.stop_req = 1'b0;
                  next_r.state = ST_IDLE;
               end else begin
                  next_r.state = ST_WAIT_RQ;
               end
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge clock) begin
      if (srst) begin
         r <= '0;
         r.state <= ST_IDLE;
         r.hstrobe <= 1'b1;
         r.dmack_n <= 1'b1;
         r.rdy_meta <= 1'b1;
         r.rdy_sync <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops.
   assign dat_o = r.rdat;
   assign ack_o = r.ack;
   assign d_out = r.d_out;
   assign d_oe = r.d_oe;
   assign hstrobe = r.hstrobe;
   assign stop = r.stop;
   assign dmack_n = r.dmack_n;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the link behaviour.
   // All checks run on the system clock and rest during reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Checksum on the lines for the whole drive phase, then acknowledge.
   sequence crc_phase_s;
      (r.state == ST_CRC && d_out == crc_value && d_oe)[*4]
      ##1 $rose(dmack_n);
   endsequence

   sequence data_toggle_s;
      $changed(hstrobe) && $past(r.state) == ST_SEND;
   endsequence

   seed_on_ack_a: assert property (
      $fell(dmack_n) |-> crc_value == CRC_SEED)
      else $error("checksum not seeded at burst start");

   toggle_step_a: assert property (
      data_toggle_s |-> crc_value == crc_serial($past(crc_value),
                                                $past(r.word)))
      else $error("checksum not stepped by data toggle");

   term_strobe_a: assert property (
      ($rose(hstrobe) && $past(r.state) == ST_STOP) |-> $stable(crc_value))
      else $error("termination strobe stepped the checksum");

   crc_drive_a: assert property (
      $rose(r.state == ST_CRC) |-> crc_phase_s)
      else $error("checksum not driven before acknowledge release");

   crc_lines_a: assert property (
      $rose(dmack_n) |-> d_out == crc_value && d_oe && stop && hstrobe)
      else $error("checksum bits not on matching data lines");

   strobe_only_a: assert property (
      $changed(crc_value) |-> (data_toggle_s or $fell(dmack_n)))
      else $error("checksum changed without a word strobe");

   // A paused device sees no strobe toggle.
   pause_hold_a: assert property (
      (r.state == ST_SEND && r.rdy_sync) |=> $stable(hstrobe))
      else $error("strobe toggled while device paused");

   // Every data toggle consumes exactly one word of the count.
   count_step_a: assert property (
      data_toggle_s |-> r.remain == $past(r.remain) - 16'h0001)
      else $error("word count not stepped by data toggle");

   // Stop stays asserted until acknowledge is released.
   stop_hold_a: assert property (
      (stop && !dmack_n) |=> stop)
      else $error("stop dropped inside a burst");

   // While the checksum stands, strobe and stop are held asserted.
   crc_strobe_a: assert property (
      (r.state == ST_CRC) |-> hstrobe && stop && d_oe)
      else $error("strobe or stop low while checksum stands");

   // Each acknowledge opens one new burst result.
   burst_count_a: assert property (
      $fell(dmack_n) |-> r.bursts == $past(r.bursts) + 8'h01)
      else $error("burst count not stepped at acknowledge");

   // Data lines are driven for the whole acknowledged burst.
   drive_ack_a: assert property (
      !dmack_n |-> d_oe)
      else $error("data lines released inside a burst");

   // The reported checksum is the one sent with acknowledge release.
   sent_crc_a: assert property (
      $rose(dmack_n) |-> r.sent_crc == crc_value)
      else $error("reported checksum differs from sent one");

   // An idle host holds acknowledge released and the lines undriven.
   idle_lines_a: assert property (
      (r.state == ST_IDLE) |-> dmack_n && !d_oe)
      else $error("idle host drives the link");

endmodule

// ### logic/udma_crc16.sv
// Sixteen-bit burst checksum register with seed load and word update.
`timescale 1ns/10ps

module udma_crc16 (
   input wire logic clock,
   input wire logic srst,
   input wire logic load,
   input wire logic update,
   input wire logic [15:0] word,
   output logic [15:0] value
);
   import udma_host_pkg::*;

   typedef struct packed {
      logic [15:0] current_checksum_value;
   } crc_state_t;

   crc_state_t r;
   crc_state_t next_r;
   logic [15:0] next_checksum_value;

   // Seed wins over update; update steps once per data word.
   always_comb begin
      next_r = r;
      next_checksum_value = crc_next(r.current_checksum_value, word);
      if (load) begin
         next_r.current_checksum_value = CRC_SEED;
      end else if (update) begin
         next_r.current_checksum_value = next_checksum_value;
      end
   end

   // State register.
   always_ff @(posedge clock) begin
      if (srst) begin
         r.current_checksum_value <= CRC_SEED;
      end else begin
         r <= next_r;
      end
   end

   assign value = r.current_checksum_value;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Parallel step matches sixteen serial shifts through the generator.
   serial_match_a: assert property (
      (update && !load) |=> value == crc_serial($past(value), $past(word)))
      else $error("parallel checksum differs from serial shift");

   // Next bit twelve written out by hand from its feedback terms.
   function automatic logic bit12_ref(input logic [15:0] c,
                                      input logic [15:0] d);
      logic f1;
      logic f4;
      logic f5;
      logic f8;
      logic f9;
      logic f12;
      logic f16;
      f1 = d[0] ^ c[15];
      f4 = d[3] ^ c[12];
      f5 = d[4] ^ c[11] ^ f1;
      f8 = d[7] ^ c[8] ^ f4;
      f9 = d[8] ^ c[7] ^ f5;
      f12 = d[11] ^ c[4] ^ f1 ^ f8;
      f16 = d[15] ^ c[0] ^ f5 ^ f12;
      return f4 ^ f9 ^ f16;
   endfunction

   // Bit twelve follows feedback terms four, nine and sixteen.
   bit_twelve_a: assert property (
      (update && !load) |=> value[12] == bit12_ref($past(value),
                                                   $past(word)))
      else $error("checksum bit twelve wrong");

endmodule

// ### logic/udma_host_pkg.sv
// Constants, register map and checksum functions for the burst host.
package udma_host_pkg;

   // Clock period in nanoseconds; link timing in nanoseconds and in clock cycles.
   localparam int CLK_NS = 25;
   localparam int STROBE_NS = 120;
   localparam int TSS_NS = 50;
   localparam int TDVS_NS = 70;
   localparam int TACK_NS = 20;
   localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] TSS_CYC = 8'((TSS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] TDVS_CYC = 8'((TDVS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] TACK_CYC = 8'((TACK_NS + CLK_NS - 1) / CLK_NS);

   // Checksum seed and generator (terms at sixteen, twelve, five, zero).
   localparam logic [15:0] CRC_SEED = 16'h4ABA;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   // Register byte addresses.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_COUNT = 8'h04;
   localparam logic [7:0] REG_WORD = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_CRC = 8'h10;

   // Control field positions.
   localparam int CTRL_START = 0;
   localparam int CTRL_ULTRA = 1;
   localparam int CTRL_STOP = 2;

   // Status field positions.
   localparam int STAT_BUSY = 0;
   localparam int STAT_PENDING = 1;
   localparam int STAT_DONE = 2;
   localparam int STAT_ULTRA = 3;
   localparam int STAT_STOP = 4;
   localparam int STAT_BURSTS = 8;

   // Values after reset.
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] TIMER_RESET = 8'h00;

   // One-hot link states.
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_WAIT_RQ = 6'h02,
      ST_SEND = 6'h04,
      ST_STOP = 6'h08,
      ST_CRC = 6'h10,
      ST_RELEASE = 6'h20
   } state_t;

   // Word-parallel checksum step, feedback-term form.
   function automatic logic [15:0] crc_next(input logic [15:0] c,
                                            input logic [15:0] d);
      logic [16:1] f;
      logic [15:0] n;
      f[1] = d[0] ^ c[15];
      f[2] = d[1] ^ c[14];
      f[3] = d[2] ^ c[13];
      f[4] = d[3] ^ c[12];
      f[5] = d[4] ^ c[11] ^ f[1];
      f[6] = d[5] ^ c[10] ^ f[2];
      f[7] = d[6] ^ c[9] ^ f[3];
      f[8] = d[7] ^ c[8] ^ f[4];
      f[9] = d[8] ^ c[7] ^ f[5];
      f[10] = d[9] ^ c[6] ^ f[6];
      f[11] = d[10] ^ c[5] ^ f[7];
      f[12] = d[11] ^ c[4] ^ f[1] ^ f[8];
      f[13] = d[12] ^ c[3] ^ f[2] ^ f[9];
      f[14] = d[13] ^ c[2] ^ f[3] ^ f[10];
      f[15] = d[14] ^ c[1] ^ f[4] ^ f[11];
      f[16] = d[15] ^ c[0] ^ f[5] ^ f[12];
      n[0] = f[16];
      n[1] = f[15];
      n[2] = f[14];
      n[3] = f[13];
      n[4] = f[12];
      n[5] = f[11] ^ f[16];
      n[6] = f[10] ^ f[15];
      n[7] = f[9] ^ f[14];
      n[8] = f[8] ^ f[13];
      n[9] = f[7] ^ f[12];
      n[10] = f[6] ^ f[11];
      n[11] = f[5] ^ f[10];
      n[12] = f[4] ^ f[9] ^ f[16];
      n[13] = f[3] ^ f[8] ^ f[15];
      n[14] = f[2] ^ f[7] ^ f[14];
      n[15] = f[1] ^ f[6] ^ f[13];
      return n;
   endfunction

   // Bit-serial reference: data bit zero enters first, bit fifteen last.
   function automatic logic [15:0] crc_serial(input logic [15:0] c,
                                              input logic [15:0] d);
      logic [15:0] s;
      logic fb;
      s = c;
      for (int i = 0; i < 16; i++) begin
         fb = s[15] ^ d[i];
         s = {s[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return s;
   endfunction

   // Merges the two low byte lanes of a bus write into a 16-bit field.
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel);
      logic [15:0] m;
      m = old;
      if (sel[0]) begin
         m[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         m[15:8] = wdat[15:8];
      end
      return m;
   endfunction

endpackage

// ### test/udma_burst_crc_checker_tb.sv
// Self-checking bench for the burst host against the device model.
`timescale 1ns/10ps

module udma_burst_crc_checker_tb;
   import udma_host_pkg::*;

   logic clock, srst, cyc_i, stb_i, we_i, ack_o, d_oe, hstrobe, stop;
   logic dmack_n, dmarq, ddmardy_n, go, pause, new_cmd, err_seen;
   logic [7:0] adr_i, limit, corrupt, err_burst, err_reg, bursts, words;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [15:0] d_out, last_rx, exp;
   int mismatches, cmp_count;

   udma_burst_host DUT (.clock(clock), .srst(srst), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dmarq(dmarq),
      .ddmardy_n(ddmardy_n), .d_in(16'h0000), .d_out(d_out), .d_oe(d_oe),
      .hstrobe(hstrobe), .stop(stop), .dmack_n(dmack_n));

   udma_device_model peer (.clock(clock), .srst(srst), .go(go),
      .pause(pause), .new_cmd(new_cmd), .limit(limit), .corrupt(corrupt),
      .hstrobe(hstrobe), .stop(stop), .dmack_n(dmack_n), .d_out(d_out),
      .dmarq(dmarq), .ddmardy_n(ddmardy_n), .err_seen(err_seen),
      .err_burst(err_burst), .err_reg(err_reg), .bursts(bursts),
      .words(words), .last_rx(last_rx));

   // Free-running 40 MHz clock.
   always #12.5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // Compares one value, counting and reporting a difference.
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, want, seen);
      end
   endtask

   // One classic bus cycle, held until the acknowledge is sampled.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= d;
      do begin
         @(posedge clock);
      end while (ack_o !== 1'b1);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clock);
   endtask

   // Reference checksum step, serial with data bit zero first.
   function automatic logic [15:0] ref_step(input logic [15:0] c,
                                            input logic [15:0] w);
      for (int i = 0; i < 16; i++) begin
         c = (c << 1) ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction

   // Starts an Ultra command, feeds n words and waits for its end.
   task automatic run_cmd(input int n, input logic [7:0] lim,
                          input logic [7:0] mask);
      logic [15:0] w;
      int first;
      int k;
      new_cmd <= 1'b1;
      limit <= lim;
      corrupt <= mask;
      @(posedge clock);
      new_cmd <= 1'b0;
      wb(1'b1, REG_COUNT, 32'(n), q);
      wb(1'b1, REG_CTRL, 32'h0000_0003, q);
      first = (lim == 8'h00) ? 0 : ((n - 1) / int'(lim)) * int'(lim);
      exp = 16'h4ABA;
      for (int i = 0; i < n; i++) begin
         w = (i == n - 1) ? 16'hFFFF : 16'h5A00 ^ (16'(i) * 16'h1357);
         wb(1'b1, REG_WORD, {16'h0000, w}, q);
         if (i >= first) begin
            exp = ref_step(exp, w);
         end
      end
      k = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0000_0000, q);
         k++;
      end while (q[STAT_BUSY] !== 1'b0 && k < 500);
      check("done", q[STAT_DONE], 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Idle levels after reset and an unmapped read.
   task automatic t_reset();
      check("idle lines", {hstrobe, dmack_n, stop, d_oe}, 32'hC);
      wb(1'b0, 8'h20, 32'h0000_0000, q);
      check("unmapped", q, 32'h0);
      $display("test reset done");
   endtask

   // One burst with a pause in it; both checksums must agree.
   task automatic t_single();
      logic h;
      fork
         run_cmd(4, 8'h00, 8'h00);
         begin
            wait (words == 8'h01);
            @(posedge clock);
            pause <= 1'b1;
            repeat (10) @(posedge clock);
            h = hstrobe;
            repeat (20) @(posedge clock);
            check("paused strobe", hstrobe, h);
            pause <= 1'b0;
         end
      join
      wb(1'b0, REG_CRC, 32'h0000_0000, q);
      check("host crc", q, exp);
      check("crc on lines", last_rx, exp);
      check("words", words, 32'h4);
      check("no error", err_seen, 32'h0);
      $display("test single done");
   endtask

   // Device ends each burst after two words; the host resumes.
   task automatic t_split();
      run_cmd(5, 8'h02, 8'h00);
      check("bursts", q[15:8], 32'h3);
      check("model bursts", bursts, 32'h3);
      check("last crc", last_rx, exp);
      check("words", words, 32'h5);
      check("no error", err_seen, 32'h0);
      $display("test split done");
   endtask

   // Miscompares on the first and third bursts, then a clean command.
   task automatic t_errors();
      run_cmd(3, 8'h01, 8'h05);
      check("error kept", err_seen, 32'h1);
      check("first error", err_burst, 32'h0);
      check("error bits", err_reg, 32'h84);
      run_cmd(2, 8'h00, 8'h00);
      check("error cleared", err_seen, 32'h0);
      $display("test errors done");
   endtask

   // Start without Ultra must not open a burst; stop while idle ignored.
   task automatic t_modes();
      wb(1'b1, REG_COUNT, 32'h0000_0002, q);
      wb(1'b1, REG_CTRL, 32'h0000_0001, q);
      wb(1'b1, REG_CTRL, 32'h0000_0004, q);
      repeat (20) @(posedge clock);
      check("no burst", dmack_n, 32'h1);
      wb(1'b0, REG_STATUS, 32'h0000_0000, q);
      check("not busy", q[STAT_BUSY], 32'h0);
      wb(1'b0, REG_COUNT, 32'h0000_0000, q);
      check("count", q[15:0], 32'h2);
      // A stop request mid-command ends it after the current burst.
      new_cmd <= 1'b1;
      @(posedge clock);
      new_cmd <= 1'b0;
      wb(1'b1, REG_COUNT, 32'h0000_0004, q);
      wb(1'b1, REG_CTRL, 32'h0000_0003, q);
      wb(1'b1, REG_WORD, 32'h0000_1234, q);
      wait (words == 8'h01);
      @(posedge clock);
      wb(1'b1, REG_CTRL, 32'h0000_0006, q);
      repeat (40) @(posedge clock);
      wb(1'b0, REG_STATUS, 32'h0000_0000, q);
      check("stop done", q[STAT_DONE], 32'h1);
      wb(1'b0, REG_COUNT, 32'h0000_0000, q);
      check("count left", q[15:0], 32'h3);
      check("stop words", words, 32'h1);
      check("stop crc", last_rx, ref_step(16'h4ABA, 16'h1234));
      $display("test modes done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      clock = 1'b0;
      srst = 1'b1;
      {cyc_i, stb_i, we_i, pause, new_cmd} = 5'h00;
      go = 1'b1;
      adr_i = 8'h00;
      sel_i = 4'hF;
      dat_i = 32'h0000_0000;
      limit = 8'h00;
      corrupt = 8'h00;
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_single();
      t_split();
      t_errors();
      t_modes();
      finish_test();
   end

   // Watchdog against a hang.
   initial begin
      repeat (60000) @(posedge clock);
      mismatches++;
      finish_test();
   end

endmodule

// ### test/udma_device_model.sv
// Device end of data-out bursts that keeps its own checksum and error record.
`timescale 1ns/10ps

module udma_device_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic go,
   input wire logic pause,
   input wire logic new_cmd,
   input wire logic [7:0] limit,
   input wire logic [7:0] corrupt,
   input wire logic hstrobe,
   input wire logic stop,
   input wire logic dmack_n,
   input wire logic [15:0] d_out,
   output logic dmarq,
   output logic ddmardy_n,
   output logic err_seen,
   output logic [7:0] err_burst,
   output logic [7:0] err_reg,
   output logic [7:0] bursts,
   output logic [7:0] words,
   output logic [15:0] last_rx
);

   logic hs_q;
   logic in_burst;
   logic term;
   logic [7:0] cnt;
   logic [15:0] crc;

   ////////////////////////////////////////////////////////////////////////////
   // Serial step through the generator, data bit zero first.
   function automatic logic [15:0] step(input logic [15:0] c,
                                        input logic [15:0] w);
      logic fb;
      for (int i = 0; i < 16; i++) begin
         fb = c[15] ^ w[i];
         c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Burst tracking; the strobe is sampled as a word clock by the bus clock.
   always @(posedge clock) begin
      hs_q <= hstrobe;
      if (srst) begin
         dmarq <= 1'b0;
         ddmardy_n <= 1'b1;
         in_burst <= 1'b0;
         term <= 1'b0;
         err_seen <= 1'b0;
         err_burst <= 8'h00;
         bursts <= 8'h00;
         words <= 8'h00;
         last_rx <= 16'h0000;
      end else begin
         if (new_cmd) begin
            err_seen <= 1'b0;
            bursts <= 8'h00;
            words <= 8'h00;
         end
         if (!in_burst && !dmack_n) begin
            in_burst <= 1'b1;
            cnt <= 8'h00;
            crc <= 16'h4ABA ^ {15'h0000, corrupt[bursts[2:0]]};
            ddmardy_n <= pause;
         end else if (in_burst && dmack_n) begin
            in_burst <= 1'b0;
            term <= 1'b0;
            bursts <= bursts + 8'h01;
            last_rx <= d_out;
            if (d_out !== crc && !err_seen) begin
               err_seen <= 1'b1;
               err_burst <= bursts;
            end
         end else if (in_burst) begin
            if (hstrobe !== hs_q && !stop) begin
               crc <= step(crc, d_out);
               cnt <= cnt + 8'h01;
               words <= words + 8'h01;
               if (cnt + 8'h01 == limit) begin
                  term <= 1'b1;
               end
            end
            ddmardy_n <= (term || stop) ? 1'b1 : pause;
            if ((term && ddmardy_n) || stop) begin
               dmarq <= 1'b0;
            end
         end else begin
            dmarq <= go;
         end
      end
   end

   // Error register image: checksum and aborted bits together.
   assign err_reg = err_seen ? 8'h84 : 8'h00;

endmodule
